// file: src/gsw_regs.vh
// register map and constants of the gain switching parameter selector
// assumes a plain address/strobe register port, 32-bit data, byte addresses in steps of four
// Function
// RQ1: switched position gain used while switching, below 1.0 rad/s uses base gain
// RQ2: switched speed gain used while switching, below 20 rad/s uses base gain
// RQ3: switched integral time used while switching, below 0.1 ms uses base value
// RQ4: position, speed, integral switched values only honoured in manual adjust mode 3
// RQ5: switched vibration frequency used, below 0.1 Hz falls back to base
// RQ6: switched resonance frequency used, below 0.1 Hz falls back to base
// RQ7: vibration values honoured only with adjust 3, tuning 2, source 1
// RQ8: switched vibration damping applied, range 0.00 to 0.30, default 0.00
// RQ9: switched resonance damping applied, range 0.00 to 0.30, default 0.00
// RQ10: controller should switch vibration values only with the motor stopped; no standstill check, switched whenever the flag is set
// RQ11: switch source codes: 0 off, 1 command, 2 frequency, 3 droop, 4 speed
// RQ12: one active-switch flag moves all enabled switched values together
`ifndef GSW_REGS_VH
`define GSW_REGS_VH

// word offsets (address is byte address, steps of four)
`define GSW_OFF_BASE_POS      8'h00
`define GSW_OFF_BASE_SPD      8'h04
`define GSW_OFF_BASE_INT      8'h08
`define GSW_OFF_BASE_VIB      8'h0c
`define GSW_OFF_BASE_RES      8'h10
`define GSW_OFF_BASE_VDMP     8'h14
`define GSW_OFF_BASE_RDMP     8'h18
`define GSW_OFF_SW_POS        8'h1c
`define GSW_OFF_SW_SPD        8'h20
`define GSW_OFF_SW_INT        8'h24
`define GSW_OFF_SW_VIB        8'h28
`define GSW_OFF_SW_RES        8'h2c
`define GSW_OFF_SW_VDMP       8'h30
`define GSW_OFF_SW_RDMP       8'h34
`define GSW_OFF_MODE          8'h38
`define GSW_OFF_CTRL          8'h3c
`define GSW_OFF_STATUS        8'h40

// mode register fields
`define GSW_MODE_ADJ_LSB      0
`define GSW_MODE_TUNE_LSB     4
`define GSW_MODE_SRC_LSB      8

// mode codes
`define GSW_ADJ_MANUAL        4'h3
`define GSW_TUNE_MANUAL       4'h2
`define GSW_SRC_OFF           4'h0
`define GSW_SRC_CMD           4'h1
`define GSW_SRC_FREQ          4'h2
`define GSW_SRC_DROOP         4'h3
`define GSW_SRC_SPEED         4'h4

// fallback thresholds and damping ceiling in parameter units
// position gain in 0.1 rad/s, speed gain in rad/s, integral in 0.1 ms,
// frequencies in 0.1 Hz, damping in 0.01
`define GSW_MIN_POS           16'h000a
`define GSW_MIN_SPD           16'h0014
`define GSW_MIN_INT           16'h0001
`define GSW_MIN_FREQ          16'h0001
`define GSW_MAX_DMP           16'h001e

// reset values
`define GSW_RST_PARAM         16'h0000
`define GSW_RST_MODE          12'h000

`endif

// file: src/gsw_pick.v
// one parameter channel: switched value or base value
// assumes both values are static or change only between control updates
`timescale 1ns/1ps
module gsw_pick #(
  parameter       W = 16
) (
  input  wire [W-1:0] base_i,
  input  wire [W-1:0] switched_i,
  input  wire [W-1:0] floor_i,
  input  wire         use_floor_i,
  input  wire         enable_i,
  input  wire         active_i,
  output wire [W-1:0] value_o,
  output wire         took_switched_o
);
  // below the floor the switched value means "same as base"
  wire below = use_floor_i && (switched_i < floor_i);
  assign took_switched_o = active_i && enable_i && !below;
  assign value_o         = took_switched_o ? switched_i : base_i;
endmodule // gsw_pick

// file: src/gsw_select.v
// gain switching parameter selector: register file plus seven selectors
// assumes single-cycle strobes from the controller, synchronous reset
`timescale 1ns/1ps
`include "gsw_regs.vh"
module gsw_select #(
  parameter          PW = 16
) (
  input  wire          clk_i,
  input  wire          reset_i,
  input  wire [7:0]    addr_i,
  input  wire [31:0]   wdata_i,
  input  wire          wr_i,
  input  wire          rd_i,
  output reg  [31:0]   rdata_o,
  input  wire          switch_cond_i,
  output reg  [PW-1:0] position_gain_o,
  output reg  [PW-1:0] speed_gain_o,
  output reg  [PW-1:0] integral_comp_o,
  output reg  [PW-1:0] vib_freq_o,
  output reg  [PW-1:0] res_freq_o,
  output reg  [PW-1:0] vib_damping_o,
  output reg  [PW-1:0] res_damping_o,
  output reg           switch_active_o
);
  localparam N = 7;

  // base set 0..6, switched set 7..13
  reg  [PW-1:0] par_q [0:2*N-1];
  reg  [3:0]    adj_q;
  reg  [3:0]    tune_q;
  reg  [3:0]    src_q;
  reg           cmd_q;

  function [PW-1:0] clamp_dmp;
    input [31:0] v;
    begin
      if (v[PW-1:0] > `GSW_MAX_DMP)
        clamp_dmp = `GSW_MAX_DMP; // RQ8 RQ9
      else
        clamp_dmp = v[PW-1:0];
    end
  endfunction

  function is_damp;
    input integer k;
    begin
      is_damp = (k == 5) || (k == 6) || (k == 12) || (k == 13);
    end
  endfunction

  // source selects whether the controller command or the external
  // condition detector drives the flag
  reg active_d;
  always @* begin
    case (src_q)
      `GSW_SRC_OFF:   active_d = 1'b0; // RQ11
      `GSW_SRC_CMD:   active_d = cmd_q; // RQ11
      `GSW_SRC_FREQ,
      `GSW_SRC_DROOP,
      `GSW_SRC_SPEED: active_d = switch_cond_i; // RQ11
      default:        active_d = 1'b0;
    endcase
  end

  wire manual_adj = (adj_q == `GSW_ADJ_MANUAL);
  wire gain_en    = manual_adj; // RQ4
  wire vib_en     = manual_adj && (tune_q == `GSW_TUNE_MANUAL)
                    && (src_q == `GSW_SRC_CMD); // RQ7

  // separate loop variables so each clocked process owns its own
  integer i;
  integer j;
  always @(posedge clk_i) begin
    if (reset_i) begin
      for (i = 0; i < 2*N; i = i + 1)
        par_q[i] <= `GSW_RST_PARAM; // RQ8 RQ9
      adj_q  <= 4'h0;
      tune_q <= 4'h0;
      src_q  <= 4'h0;
      cmd_q  <= 1'b0;
    end else if (wr_i) begin
      for (i = 0; i < 2*N; i = i + 1)
        if (addr_i == i*4)
          par_q[i] <= is_damp(i) ? clamp_dmp(wdata_i) : wdata_i[PW-1:0];
      if (addr_i == `GSW_OFF_MODE) begin
        adj_q  <= wdata_i[`GSW_MODE_ADJ_LSB +: 4];
        tune_q <= wdata_i[`GSW_MODE_TUNE_LSB +: 4];
        src_q  <= wdata_i[`GSW_MODE_SRC_LSB +: 4];
      end
      if (addr_i == `GSW_OFF_CTRL)
        cmd_q <= wdata_i[0];
    end
  end

  // selectors all share one flag so a switch moves every enabled value at once
  wire [PW-1:0] sel   [0:N-1];
  wire [N-1:0]  took;
  wire [PW-1:0] floor_v [0:N-1];
  assign floor_v[0] = `GSW_MIN_POS; // RQ1
  assign floor_v[1] = `GSW_MIN_SPD; // RQ2
  assign floor_v[2] = `GSW_MIN_INT; // RQ3
  assign floor_v[3] = `GSW_MIN_FREQ; // RQ5
  assign floor_v[4] = `GSW_MIN_FREQ; // RQ6
  assign floor_v[5] = {PW{1'b0}};
  assign floor_v[6] = {PW{1'b0}};

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_pick
      gsw_pick #(.W(PW)) u_pick (
        .base_i          (par_q[g]),
        .switched_i      (par_q[g+N]),
        .floor_i         (floor_v[g]),
        .use_floor_i     (g < 5),
        .enable_i        ((g < 3) ? gain_en : vib_en),
        .active_i        (switch_active_o), // RQ12
        .value_o         (sel[g]),
        .took_switched_o (took[g])
      );
    end
  endgenerate

  // registered outputs; vibration values should only be switched at
  // standstill, which is left to the controller (RQ10)
  always @(posedge clk_i) begin
    if (reset_i) begin
      switch_active_o <= 1'b0;
      position_gain_o <= `GSW_RST_PARAM;
      speed_gain_o    <= `GSW_RST_PARAM;
      integral_comp_o <= `GSW_RST_PARAM;
      vib_freq_o      <= `GSW_RST_PARAM;
      res_freq_o      <= `GSW_RST_PARAM;
      vib_damping_o   <= `GSW_RST_PARAM;
      res_damping_o   <= `GSW_RST_PARAM;
    end else begin
      switch_active_o <= active_d; // RQ12
      position_gain_o <= sel[0]; // RQ1
      speed_gain_o    <= sel[1]; // RQ2
      integral_comp_o <= sel[2]; // RQ3
      vib_freq_o      <= sel[3]; // RQ5
      res_freq_o      <= sel[4]; // RQ6
      vib_damping_o   <= sel[5]; // RQ8
      res_damping_o   <= sel[6]; // RQ9
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= 32'h0000_0000;
      for (j = 0; j < 2*N; j = j + 1)
        if (addr_i == j*4)
          rdata_o <= {{(32-PW){1'b0}}, par_q[j]};
      if (addr_i == `GSW_OFF_MODE)
        rdata_o <= {20'h00000, src_q, tune_q, adj_q};
      if (addr_i == `GSW_OFF_CTRL)
        rdata_o <= {31'h0000_0000, cmd_q};
      if (addr_i == `GSW_OFF_STATUS)
        rdata_o <= {16'h0000, 6'h00, took, switch_active_o, vib_en, gain_en};
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule // gsw_select

// file: testbench/gsw_ctrl_model.sv
// controller model: register master facing the selector
// assumes the shared 100 MHz clock
`timescale 1ns/1ps
module gsw_ctrl_model (
  input  logic        clk_i,
  input  logic [31:0] rdata_i,
  output logic [7:0]  addr_o = 8'h00,
  output logic [31:0] wdata_o = 32'h0,
  output logic        wr_o = 1'b0,
  output logic        rd_o = 1'b0
);
  // switch commands go out with no check that the motor is at rest
  task put(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= v;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
    end
  endtask
  task get(input [7:0] a, output [31:0] v);
    begin
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      // read data stand only in the cycle after the strobe: take them at its end
      @(posedge clk_i);
      v = rdata_i;
    end
  endtask
endmodule // gsw_ctrl_model

// file: testbench/gsw_select_properties.sv
// checker: port properties of the selector
// assumes one clock, sync high reset
`timescale 1ns/1ps
module gsw_select_properties #(parameter PW = 16) (
  input logic          clk_i,
  input logic          reset_i,
  input logic          wr_i,
  input logic          rd_i,
  input logic [31:0]   rdata_o,
  input logic [PW-1:0] position_gain_o,
  input logic [PW-1:0] vib_freq_o,
  input logic [PW-1:0] vib_damping_o,
  input logic [PW-1:0] res_damping_o,
  input logic          switch_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0) else $error("rdata not idle");
  rd_upper_a: assert property (rd_i |=> rdata_o[31:16] == 16'h0) else $error("rdata high");
  rst_flag_a: assert property (disable iff (1'b0) reset_i |=> !switch_active_o)
    else $error("flag after reset");
  rst_pos_a: assert property (disable iff (1'b0) reset_i |=> position_gain_o == '0)
    else $error("gain after reset");
  vdmp_max_a: assert property (vib_damping_o <= 16'h001e) else $error("vib damping");
  rdmp_max_a: assert property (res_damping_o <= 16'h001e) else $error("res damping");
  hold_pos_a: assert property (!wr_i && !$past(wr_i) && $stable(switch_active_o)
    |=> $stable(position_gain_o)) else $error("gain moved");
  hold_vib_a: assert property (!wr_i && !$past(wr_i) && $stable(switch_active_o)
    |=> $stable(vib_freq_o)) else $error("vib freq moved");
endmodule // gsw_select_properties
bind gsw_select gsw_select_properties #(.PW(PW)) i_chk (.clk_i(clk_i), .reset_i(reset_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .position_gain_o(position_gain_o),
  .vib_freq_o(vib_freq_o), .vib_damping_o(vib_damping_o), .res_damping_o(res_damping_o),
  .switch_active_o(switch_active_o));

// file: testbench/test_gsw_select.sv
// bench: scenarios for the parameter selector
// assumes the controller model is the only register master
`timescale 1ns/1ps
`include "gsw_regs.vh"
`define CHK(n, e, v) begin check_count++; if ((v) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h seen %h", n, e, v); end end
module test_gsw_select;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        cond = 1'b0;
  int          check_count = 0;
  int          miscompares = 0;
  int          k;
  logic [31:0] d;
  logic [7:0]  tb [14] = '{8'h64, 8'h32, 8'h20, 8'h40, 8'h48, 8'h05, 8'h06,
    8'h09, 8'h14, 8'h00, 8'h01, 8'h00, 8'h40, 8'h1d};
  wire  [7:0]  a;
  wire  [31:0] wd, rdat;
  wire  [15:0] p, s, i, v, r, x, y;
  wire         wr, rd, f;
  always #5 clk_i = ~clk_i;
  gsw_ctrl_model m (.clk_i(clk_i), .rdata_i(rdat), .addr_o(a), .wdata_o(wd), .wr_o(wr),
    .rd_o(rd));
  gsw_select i_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(a), .wdata_i(wd), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdat), .switch_cond_i(cond), .position_gain_o(p), .speed_gain_o(s),
    .integral_comp_o(i), .vib_freq_o(v), .res_freq_o(r), .vib_damping_o(x),
    .res_damping_o(y), .switch_active_o(f));
  task outs(input [15:0] ep, es, ei, ev, er, ex, ey, input ef);
    begin
      `CHK("pos", ep, p)
      `CHK("spd", es, s)
      `CHK("int", ei, i)
      `CHK("vib", ev, v)
      `CHK("res", er, r)
      `CHK("vdmp", ex, x)
      `CHK("rdmp", ey, y)
      `CHK("flag", ef, f)
    end
  endtask
  // fixed settle: flag one edge after the write, values one edge later
  task cfg(input [11:0] md, input c);
    begin
      m.put(`GSW_OFF_MODE, {20'h0, md});
      m.put(`GSW_OFF_CTRL, {31'h0, c});
      repeat (3) @(posedge clk_i);
      #1;
    end
  endtask
  task t_floor;
    begin
      cfg(12'h123, 1'b0);
      outs(16'h64, 16'h32, 16'h20, 16'h40, 16'h48, 16'h05, 16'h06, 1'b0);
      cfg(12'h123, 1'b1);
      outs(16'h64, 16'h14, 16'h20, 16'h01, 16'h48, 16'h1e, 16'h1d, 1'b1);
      // other side of each floor: at or above it switched, below it base
      m.put(`GSW_OFF_SW_POS, 32'h0000_000a);
      m.put(`GSW_OFF_SW_SPD, 32'h0000_0013);
      m.put(`GSW_OFF_SW_INT, 32'h0000_0001);
      m.put(`GSW_OFF_SW_VIB, 32'h0000_0000);
      m.put(`GSW_OFF_SW_RES, 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      #1;
      outs(16'h0a, 16'h32, 16'h01, 16'h40, 16'h01, 16'h1e, 16'h1d, 1'b1);
    end
  endtask
  task t_modes;
    begin
      cfg(12'h122, 1'b1);
      outs(16'h64, 16'h32, 16'h20, 16'h40, 16'h48, 16'h05, 16'h06, 1'b1);
      cfg(12'h113, 1'b1);
      outs(16'h0a, 16'h32, 16'h01, 16'h40, 16'h48, 16'h05, 16'h06, 1'b1);
    end
  endtask
  task t_src;
    int sr, c;
    begin
      for (sr = 0; sr < 5; sr++)
        for (c = 0; c < 2; c++) begin
          @(posedge clk_i);
          cond <= c[0];
          cfg({sr[3:0], 8'h23}, 1'b0);
          `CHK("src flag", (sr > 1) && c[0], f)
          if (sr == 4 && c == 1)
            outs(16'h0a, 16'h32, 16'h01, 16'h40, 16'h48, 16'h05, 16'h06, 1'b1);
        end
    end
  endtask
  task t_rd;
    begin
      m.get(`GSW_OFF_SW_VDMP, d);
      `CHK("vdmp read", 32'h1e, d)
      m.get(`GSW_OFF_STATUS, d);
      `CHK("status", 32'h0000_002d, d)
      m.get(8'h80, d);
      `CHK("unmapped", 32'h0, d)
    end
  endtask
  // second reset in mid-run, with the condition input still high
  task t_reset;
    begin
      @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      #1;
      outs(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
      m.get(`GSW_OFF_SW_RDMP, d);
      `CHK("rdmp after reset", 32'h0, d)
      m.get(`GSW_OFF_MODE, d);
      `CHK("mode after reset", 32'h0, d)
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    #1 outs(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
    for (k = 0; k < 14; k++)
      m.put(8'(k * 4), {24'h0, tb[k]});
    t_floor;
    t_modes;
    t_src;
    t_rd;
    t_reset;
    wrap_up;
  end
endmodule // test_gsw_select
